// ==== rtl/oscsc_top.sv ====
// oscsc_top: clock source control, register file and tick routing
// assumes crystal and external clock edges arrive as synchronous pulses
// Operation
// - route 128 Hz and 1 Hz ticks
// - rc on and selected after reset/sleep
// - two rc ranges with coarse fine trim
// - rc_osc_on gates oscillator and clock
// - sleep enables rc oscillator
// - bias hold keeps rc bias when off
// - decade range multiplies frequency by ten
// - coarse trim scales by code plus one
// - mask first 32768 crystal cycles
// - reset/sleep clear crystal, set warmup flag
// - clearing crystal_osc_on stops crystal
// - sleep stops crystal oscillator
// - external clock blocks crystal enable
// - external present after four pulses
// - cpu source select priority
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module oscsc_top (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// register port
	input  wire logic [2:0]               reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	// clock source events
	input  wire logic                     sleep_req,
	input  wire logic                     rc_edge,
	input  wire logic                     xtal_edge,
	input  wire logic                     ext_edge,
	// prescaler ticks
	input  wire logic                     tick_128hz,
	input  wire logic                     tick_1hz,
	// analog controls and clock gating
	output oscsc_pkg::oscsc_rc_ctrl_t     rc_ctrl,
	output logic                          xtal_run,
	output logic                          xtal_clk_valid,
	output logic                          rc_clk_gate,
	output oscsc_pkg::oscsc_src_t         cpu_src,
	// tick routing to interrupt and event managers
	output oscsc_pkg::oscsc_tick_map_t    tick_map
);

	logic        rc_on_r, rc_on_nxt;
	logic        xtal_on_r, xtal_on_nxt;
	logic        warm_r, warm_nxt;
	logic        bias_r, bias_nxt;
	logic        ext_allow_r, ext_allow_nxt;
	logic        ext_pres_r, ext_pres_nxt;
	logic        cpu_sel_r, cpu_sel_nxt;
	logic        rc_cold_r, rc_cold_nxt;
	logic        range_r, range_nxt;
	logic [3:0]  coarse_r, coarse_nxt;
	logic [5:0]  fine_r, fine_nxt;
	logic [15:0] warm_cnt_r, warm_cnt_nxt;
	logic [2:0]  ext_cnt_r, ext_cnt_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	logic        sleep_r, sleep_nxt;
	logic        wr_clk, wr_sleep;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	function automatic logic wr_hit(input logic [2:0] a);
		wr_hit = reg_wr && (reg_addr == a);
	endfunction

	assign wr_clk = wr_hit(oscsc_pkg::ADDR_CLOCK_CTRL);
	assign wr_sleep = wr_hit(oscsc_pkg::ADDR_SLEEP_CTRL);

	always_comb begin
		rc_on_nxt = rc_on_r;
		xtal_on_nxt = xtal_on_r;
		warm_nxt = warm_r;
		bias_nxt = bias_r;
		ext_allow_nxt = ext_allow_r;
		ext_pres_nxt = ext_pres_r;
		cpu_sel_nxt = cpu_sel_r;
		rc_cold_nxt = rc_cold_r;
		range_nxt = range_r;
		coarse_nxt = coarse_r;
		fine_nxt = fine_r;
		warm_cnt_nxt = warm_cnt_r;
		ext_cnt_nxt = ext_cnt_r;
		sleep_nxt = sleep_r;
		if (wr_clk) begin
			rc_on_nxt = reg_wdata[oscsc_pkg::BIT_RC_ON];
			// set attempts are dropped while external clock is involved
			xtal_on_nxt = reg_wdata[oscsc_pkg::BIT_XTAL_ON] &&
				!ext_pres_r && !ext_allow_r;
			bias_nxt = reg_wdata[oscsc_pkg::BIT_BIAS];
			ext_allow_nxt = reg_wdata[oscsc_pkg::BIT_EXT_ALLOW];
			cpu_sel_nxt = reg_wdata[oscsc_pkg::BIT_CPU_SEL];
		end
		if (wr_hit(oscsc_pkg::ADDR_TRIM_COARSE)) begin
			range_nxt = reg_wdata[oscsc_pkg::BIT_RANGE];
			coarse_nxt = reg_wdata[3:0];
		end
		if (wr_hit(oscsc_pkg::ADDR_TRIM_FINE)) begin
			fine_nxt = reg_wdata[5:0];
		end
		if (rc_on_r && rc_edge) begin
			rc_cold_nxt = 1'b0;
		end
		// warmup counter only runs on crystal edges while enabled
		if (!xtal_on_r || (xtal_on_nxt && !xtal_on_r)) begin
			warm_cnt_nxt = 16'h0000;
		end else if (warm_r && xtal_edge) begin
			if (warm_cnt_r == oscsc_pkg::WARMUP_LAST) begin
				warm_nxt = 1'b0;
			end else begin
				warm_cnt_nxt = warm_cnt_r + 16'h0001;
			end
		end
		if (!xtal_on_r) begin
			warm_nxt = 1'b1;
		end
		if (!ext_allow_r) begin
			ext_cnt_nxt = 3'h0;
			ext_pres_nxt = 1'b0;
		end else if (ext_edge && !ext_pres_r) begin
			ext_cnt_nxt = ext_cnt_r + 3'h1;
			if (ext_cnt_r + 3'h1 == oscsc_pkg::EXT_PULSES) begin
				ext_pres_nxt = 1'b1;
			end
		end
		if (wr_sleep) begin
			sleep_nxt = reg_wdata[0];
		end
		if (sleep_req || sleep_r) begin
			rc_on_nxt = 1'b1;
			cpu_sel_nxt = 1'b0;
			xtal_on_nxt = 1'b0;
			warm_nxt = 1'b1;
			rc_cold_nxt = 1'b1;
			warm_cnt_nxt = 16'h0000;
			sleep_nxt = 1'b0;
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				oscsc_pkg::ADDR_CLOCK_CTRL: begin
					rdata_nxt = {cpu_sel_r, ext_pres_r, ext_allow_r, bias_r,
						warm_r, rc_cold_r, xtal_on_r, rc_on_r};
				end
				oscsc_pkg::ADDR_TRIM_COARSE: begin
					rdata_nxt = {3'h0, range_r, coarse_r};
				end
				oscsc_pkg::ADDR_TRIM_FINE: begin
					rdata_nxt = {2'h0, fine_r};
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rc_on_r <= 1'b1;
			xtal_on_r <= 1'b0;
			warm_r <= 1'b1;
			bias_r <= oscsc_pkg::BIAS_RST;
			ext_allow_r <= 1'b0;
			ext_pres_r <= 1'b0;
			cpu_sel_r <= 1'b0;
			rc_cold_r <= 1'b1;
			range_r <= oscsc_pkg::RANGE_RST;
			coarse_r <= oscsc_pkg::COARSE_RST;
			fine_r <= oscsc_pkg::FINE_RST;
			warm_cnt_r <= 16'h0000;
			ext_cnt_r <= 3'h0;
			rdata_r <= 8'h00;
			sleep_r <= 1'b0;
		end else begin
			rc_on_r <= rc_on_nxt;
			xtal_on_r <= xtal_on_nxt;
			warm_r <= warm_nxt;
			bias_r <= bias_nxt;
			ext_allow_r <= ext_allow_nxt;
			ext_pres_r <= ext_pres_nxt;
			cpu_sel_r <= cpu_sel_nxt;
			rc_cold_r <= rc_cold_nxt;
			range_r <= range_nxt;
			coarse_r <= coarse_nxt;
			fine_r <= fine_nxt;
			warm_cnt_r <= warm_cnt_nxt;
			ext_cnt_r <= ext_cnt_nxt;
			rdata_r <= rdata_nxt;
			sleep_r <= sleep_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	// bias held only when requested; a running rc always needs it
	assign rc_ctrl = '{osc_on: rc_on_r, bias_on: rc_on_r | bias_r,
		decade: range_r, coarse: coarse_r, fine: fine_r};
	assign rc_clk_gate = rc_on_r;
	assign xtal_run = xtal_on_r;
	assign xtal_clk_valid = xtal_on_r && !warm_r;

	always_comb begin
		if (!cpu_sel_r) begin
			cpu_src = rc_on_r ? oscsc_pkg::OSCSC_SRC_RC
				: oscsc_pkg::OSCSC_SRC_OFF;
		end else if (xtal_on_r && !ext_pres_r && !ext_allow_r) begin
			cpu_src = oscsc_pkg::OSCSC_SRC_XTAL;
		end else begin
			cpu_src = oscsc_pkg::OSCSC_SRC_EXT;
		end
	end

	always_comb begin
		tick_map = '0;
		tick_map.irq_high[oscsc_pkg::HIGH_LINE_128] = tick_128hz;
		tick_map.events[oscsc_pkg::EVENT_LINE_128] = tick_128hz;
		tick_map.irq_mid[oscsc_pkg::MID_LINE_1] = tick_1hz;
		tick_map.events[oscsc_pkg::EVENT_LINE_1] = tick_1hz;
	end

	a_xtal_blocked: assert property (
		(wr_clk && (ext_pres_r || ext_allow_r)) |=> !xtal_on_r)
		else $error("crystal enabled while external clock involved");

	a_sleep_state: assert property (
		sleep_req |=> (rc_on_r && !xtal_on_r && warm_r && !cpu_sel_r))
		else $error("sleep did not restore rc and stop crystal");

	a_warm_hold: assert property (
		!xtal_on_r |-> (warm_r && warm_cnt_r == 16'h0000))
		else $error("warmup not held while crystal off");

	a_masked_out: assert property (
		warm_r |-> !xtal_clk_valid)
		else $error("crystal clock passed during warmup");

	a_warm_done: assert property (
		(xtal_on_r && warm_r && xtal_edge
		&& warm_cnt_r == oscsc_pkg::WARMUP_LAST
		&& !sleep_req && !sleep_r && !wr_clk) |=> !warm_r)
		else $error("warmup flag did not clear at count end");

	a_ext_detect: assert property (
		(ext_allow_r && ext_edge && ext_cnt_r == 3'h3 && !wr_clk)
		|=> ext_pres_r)
		else $error("external clock not detected after four pulses");

	a_cpu_rc: assert property (
		(!cpu_sel_r && rc_on_r) |-> cpu_src == oscsc_pkg::OSCSC_SRC_RC)
		else $error("rc not selected with select low");

	a_tick_route: assert property (
		tick_map.irq_high[6] == tick_128hz && tick_map.events[1] == tick_1hz
		&& tick_map.irq_mid[3] == tick_1hz)
		else $error("tick routing wrong");

	// sleep may come from the pin or from the register, a cycle later
	sequence s_sleep_entry;
		sleep_req || sleep_r;
	endsequence

	sequence s_xtal_start;
		!xtal_on_r ##1 xtal_on_r;
	endsequence

	a_sleep_flags: assert property (
		s_sleep_entry |=> (warm_r && rc_cold_r && !xtal_on_r))
		else $error("sleep did not set the start flags");

	a_sleep_xtal: assert property (
		s_sleep_entry |=> !xtal_run)
		else $error("crystal still running after sleep");

	a_sleep_rc: assert property (
		s_sleep_entry |=> (rc_clk_gate
		&& cpu_src == oscsc_pkg::OSCSC_SRC_RC))
		else $error("rc not running and selected after sleep");

	a_rc_stop: assert property (
		(wr_clk && !reg_wdata[oscsc_pkg::BIT_RC_ON] && !sleep_req
		&& !sleep_r) |=> !rc_clk_gate)
		else $error("rc clock still gated on after clear");

	a_bias_kept: assert property (
		(!rc_on_r && bias_r) |-> rc_ctrl.bias_on)
		else $error("rc bias dropped while hold set");

	a_bias_drop: assert property (
		(!rc_on_r && !bias_r) |-> !rc_ctrl.bias_on)
		else $error("rc bias on while rc off and hold clear");

	a_xtal_stop: assert property (
		(wr_clk && !reg_wdata[oscsc_pkg::BIT_XTAL_ON]) |=> !xtal_run)
		else $error("crystal still running after clear");

	a_warm_restart: assert property (
		s_xtal_start |-> (warm_r && warm_cnt_r == 16'h0000))
		else $error("warmup did not restart on crystal enable");

	a_range_write: assert property (
		(reg_wr && reg_addr == oscsc_pkg::ADDR_TRIM_COARSE)
		|=> rc_ctrl.decade == $past(reg_wdata[oscsc_pkg::BIT_RANGE]))
		else $error("range bit not applied");

	a_coarse_write: assert property (
		(reg_wr && reg_addr == oscsc_pkg::ADDR_TRIM_COARSE)
		|=> rc_ctrl.coarse == $past(reg_wdata[3:0]))
		else $error("coarse trim not applied");

	a_fine_write: assert property (
		(reg_wr && reg_addr == oscsc_pkg::ADDR_TRIM_FINE)
		|=> rc_ctrl.fine == $past(reg_wdata[5:0]))
		else $error("fine trim not applied");

	a_ext_clear: assert property (
		!ext_allow_r |=> !ext_pres_r)
		else $error("external present without allow");

	a_cpu_xtal: assert property (
		(cpu_sel_r && xtal_on_r && !ext_pres_r && !ext_allow_r)
		|-> cpu_src == oscsc_pkg::OSCSC_SRC_XTAL)
		else $error("crystal not selected");

	a_cpu_ext: assert property (
		(cpu_sel_r && (ext_pres_r || ext_allow_r))
		|-> cpu_src == oscsc_pkg::OSCSC_SRC_EXT)
		else $error("external clock not selected");

	a_tick_events: assert property (
		tick_map.events[oscsc_pkg::EVENT_LINE_128] == tick_128hz
		&& tick_map.irq_high[oscsc_pkg::HIGH_LINE_128] == tick_128hz)
		else $error("fast tick routing wrong");

	// read data must not linger past their one cycle
	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data stand outside the read cycle");

endmodule

`default_nettype wire

// ==== rtl/oscsc_pkg.sv ====
// oscsc_pkg: constants and carrier types for the clock source control block
// assumes a single 250 MHz system clock domain
package oscsc_pkg;

	localparam logic [2:0] ADDR_CLOCK_CTRL = 3'h0;
	localparam logic [2:0] ADDR_TRIM_COARSE = 3'h1;
	localparam logic [2:0] ADDR_TRIM_FINE = 3'h2;
	localparam logic [2:0] ADDR_SLEEP_CTRL = 3'h3;

	// clock control bit positions, then BIT_RANGE, which sits in the coarse trim register
	localparam int BIT_RC_ON = 0;
	localparam int BIT_XTAL_ON = 1;
	localparam int BIT_RC_COLD = 2;
	localparam int BIT_WARMUP = 3;
	localparam int BIT_BIAS = 4;
	localparam int BIT_EXT_ALLOW = 5;
	localparam int BIT_EXT_PRES = 6;
	localparam int BIT_CPU_SEL = 7;
	localparam int BIT_RANGE = 4;

	localparam logic [3:0] COARSE_RST = 4'h0;
	localparam logic [5:0] FINE_RST = 6'h20;
	localparam logic       RANGE_RST = 1'b0;
	localparam logic       BIAS_RST = 1'b1;

	localparam int WARMUP_CYCLES = 32768;
	// 32768 edges: counts 0..7fff, the edge seen at 7fff ends warm-up
	localparam logic [15:0] WARMUP_LAST = 16'h7fff;
	localparam logic [2:0] EXT_PULSES = 3'h4;

	localparam int HIGH_LINE_128 = 6;
	localparam int EVENT_LINE_128 = 5;
	localparam int MID_LINE_1 = 3;
	localparam int EVENT_LINE_1 = 1;

	typedef enum logic [1:0] {
		OSCSC_SRC_RC,
		OSCSC_SRC_XTAL,
		OSCSC_SRC_EXT,
		OSCSC_SRC_OFF
	} oscsc_src_t;

	typedef struct packed {
		logic       osc_on;
		logic       bias_on;
		logic       decade;
		logic [3:0] coarse;
		logic [5:0] fine;
	} oscsc_rc_ctrl_t;

	typedef struct packed {
		logic [7:0] irq_high;
		logic [7:0] irq_mid;
		logic [7:0] events;
	} oscsc_tick_map_t;

endpackage

// ==== sim/tb.sv ====
// tb: self-checking bench for the clock source control block
// assumes oscsc_top and oscsc_pkg are compiled first; one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic                          clk;
	logic                          rst_n;
	logic [2:0]                    reg_addr;
	logic [7:0]                    reg_wdata;
	logic                          reg_wr;
	logic                          reg_rd;
	logic [7:0]                    reg_rdata;
	logic                          sleep_req;
	logic                          rc_edge;
	logic                          xtal_edge;
	logic                          ext_edge;
	logic                          tick_128hz;
	logic                          tick_1hz;
	oscsc_pkg::oscsc_rc_ctrl_t     rc_ctrl;
	logic                          xtal_run;
	logic                          xtal_clk_valid;
	logic                          rc_clk_gate;
	oscsc_pkg::oscsc_src_t         cpu_src;
	oscsc_pkg::oscsc_tick_map_t    tick_map;
	int                            err_total;
	int                            total_checks;
	logic [7:0]                    v;

	oscsc_top u_oscsc_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sleep_req(sleep_req), .rc_edge(rc_edge),
		.xtal_edge(xtal_edge), .ext_edge(ext_edge), .tick_128hz(tick_128hz),
		.tick_1hz(tick_1hz), .rc_ctrl(rc_ctrl), .xtal_run(xtal_run),
		.xtal_clk_valid(xtal_clk_valid), .rc_clk_gate(rc_clk_gate),
		.cpu_src(cpu_src), .tick_map(tick_map));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		total_checks++;
		if (e !== g) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe edge
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// one-cycle pulses with a gap, so each counts as a separate edge
	task automatic pulses(input bit ext, input int n);
		repeat (n) begin
			@(posedge clk);
			if (ext) ext_edge <= 1'b1; else xtal_edge <= 1'b1;
			@(posedge clk);
			ext_edge <= 1'b0;
			xtal_edge <= 1'b0;
		end
	endtask

	task automatic t_reset;
		rd(3'h0, v); chk("ctrl rst", 8'h1d, v);
		@(posedge clk);
		rc_edge <= 1'b1;
		@(posedge clk);
		rc_edge <= 1'b0;
		rd(3'h0, v); chk("rc cold clr", 8'h00, v & 8'h04);
		rd(3'h1, v); chk("coarse rst", 8'h00, v);
		rd(3'h2, v); chk("fine rst", 8'h20, v);
		rd(3'h5, v); chk("unmapped", 8'h00, v);
		chk("rc_ctrl rst", 13'h1820, rc_ctrl);
		chk("src rst", oscsc_pkg::OSCSC_SRC_RC, cpu_src);
	endtask

	task automatic t_ticks;
		@(posedge clk);
		tick_128hz <= 1'b1;
		#1;
		chk("map 128", 24'h400020, tick_map);
		@(posedge clk);
		tick_128hz <= 1'b0;
		tick_1hz <= 1'b1;
		#1;
		chk("map 1", 24'h000802, tick_map);
		@(posedge clk);
		tick_1hz <= 1'b0;
	endtask

	task automatic t_trim;
		wr(3'h1, 8'h1f);
		wr(3'h2, 8'h3f);
		settle(1);
		chk("trim", 13'h1fff, rc_ctrl);
		rd(3'h1, v); chk("coarse rd", 8'h1f, v);
	endtask

	// crystal warm-up, cpu select, rc off with bias held, then sleep
	task automatic t_crystal;
		wr(3'h0, 8'h13);
		settle(1);
		chk("xtal run", 1'b1, xtal_run);
		pulses(1'b0, 32767);
		settle(2);
		chk("masked", 1'b0, xtal_clk_valid);
		pulses(1'b0, 1);
		settle(2);
		chk("valid", 1'b1, xtal_clk_valid);
		rd(3'h0, v); chk("warm clr", 8'h00, v & 8'h08);
		wr(3'h0, 8'h93);
		settle(1);
		chk("src xtal", oscsc_pkg::OSCSC_SRC_XTAL, cpu_src);
		wr(3'h0, 8'h92);
		settle(1);
		chk("rc gate", 1'b0, rc_clk_gate);
		chk("bias", 2'b01, {rc_ctrl.osc_on, rc_ctrl.bias_on});
		@(posedge clk);
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		settle(1);
		chk("sleep rc", 1'b1, rc_clk_gate);
		chk("sleep xtal", 1'b0, xtal_run);
		rd(3'h0, v); chk("sleep reg", 8'h19, v & 8'h9b);
		wr(3'h0, 8'h13);
		wr(3'h0, 8'h11);
		settle(1);
		chk("xtal off", 1'b0, xtal_run);
	endtask

	task automatic t_ext;
		wr(3'h0, 8'h21);
		pulses(1'b1, 4);
		settle(2);
		rd(3'h0, v); chk("ext pres", 8'h40, v & 8'h40);
		wr(3'h0, 8'h23);
		settle(1);
		chk("xtal blocked", 1'b0, xtal_run);
		wr(3'h0, 8'ha3);
		settle(1);
		chk("src ext", oscsc_pkg::OSCSC_SRC_EXT, cpu_src);
	endtask

	initial begin
		rst_n = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, sleep_req} = '0;
		{rc_edge, xtal_edge, ext_edge, tick_128hz, tick_1hz} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_ticks;
		t_trim;
		t_crystal;
		t_ext;
		test_done;
	end

	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		test_done;
	end
endmodule

`default_nettype wire
